// File: testbench/sleep_mode_controller_test.sv
// self-checking bench for the sleep mode controller
// assumes smc_cpu_model stands in for the cpu core and interrupt controller
`timescale 1ns/10ps
module sleep_mode_controller_test;
    import smc_pkg::*;
    localparam int OSC_CYC = 2;
    logic       ref_clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       nvm_busy = 1'b0;
    logic       rtc_en = 1'b1;
    logic [7:0] pr = 8'h00;
    logic [2:0] mode;
    logic       sleep_enable_bit, sexec, run, slp, wirq, cc, nc, pc, rc, so, ro;
    logic [3:0] irq;
    logic [7:0] pce;
    logic [5:0] en6;
    int         miscompares = 0;
    int         num_checks = 0;
    assign en6 = {cc, nc, pc, rc, so, ro};
    always #2 ref_clk_i = ~ref_clk_i;
    smc_cpu_model smc_cpu_model_i (.ref_clk_i(ref_clk_i), .wake_irq_i(wirq),
        .sleep_mode_select_o(mode), .sleep_enable_bit_o(sleep_enable_bit), .sleep_exec_o(sexec),
        .irq_o(irq));
    smc_ctrl #(.NUM_PERIPH(8), .OSC_START_CYC(OSC_CYC)) smc_ctrl_i (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .ce_i(1'b1), .sleep_mode_select_i(mode), .sleep_enable_bit_i(sleep_enable_bit),
        .sleep_exec_i(sexec), .nvm_busy_i(nvm_busy), .rtc_enabled_i(rtc_en),
        .irq_async_port_i(irq[0]), .irq_twi_addr_i(irq[1]), .irq_rtc_i(irq[2]),
        .irq_other_i(irq[3]), .power_reduce_i(pr), .cpu_run_o(run), .asleep_o(slp),
        .wake_irq_o(wirq), .clk_cpu_en_o(cc), .clk_nvm_en_o(nc), .clk_per_en_o(pc),
        .clk_rtc_en_o(rc), .sys_osc_en_o(so), .rtc_osc_en_o(ro), .periph_clk_en_o(pce));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic awake(input string name);
        check({name, " run"}, run, 1'b1);
        check({name, " asleep"}, slp, 1'b0);
        check({name, " clocks"}, en6, 6'h3F);
    endtask
    // sleep in a mode, show a refused source, then wake and time the halt
    task automatic sleep_wake(input logic [2:0] m, input logic [5:0] exp, input logic [3:0] pre,
                              input logic [3:0] wk, input logic osc_on);
        int n;
        int h;
        int s;
        h = 0;
        s = 0;
        smc_cpu_model_i.sleep_cmd(m, 1'b1);
        @(negedge ref_clk_i);
        check("asleep", slp, 1'b1);
        check("run", run, 1'b0);
        check("clocks", en6, exp);
        check("periph", pce, m == 3'h0 ? 8'hFF : 8'h00);
        smc_cpu_model_i.raise(pre);
        repeat (20) @(negedge ref_clk_i);
        check("refused wake", slp, 1'b1);
        smc_cpu_model_i.raise(pre | wk);
        for (n = 0; n < 400 && run !== 1'b1; n++) begin
            if (slp === 1'b0) h++;
            if (so === 1'b1) s++;
            @(negedge ref_clk_i);
        end
        check("woke", run, 1'b1);
        check("wake pulse", wirq, 1'b1);
        if (osc_on) check("halt", h, 4);
        else check("osc wait", s, OSC_CYC + 4);
        awake("resumed");
        @(negedge ref_clk_i);
        check("wake pulse end", wirq, 1'b0);
        // the cleared wake pins need four edges to leave the synchronisers
        repeat (4) @(negedge ref_clk_i);
        $display("test sleep mode %h done", m);
    endtask
    task automatic refused;
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
        foreach (codes[i]) begin
            smc_cpu_model_i.sleep_cmd(codes[i], i != 0);
            repeat (2) @(negedge ref_clk_i);
            awake("refused");
        end
        $display("test refused done");
    endtask
    task automatic nvm_and_gating;
        pr = 8'hA5;
        nvm_busy = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("gated", pce, 8'h5A);
        smc_cpu_model_i.sleep_cmd(3'h0, 1'b1);
        repeat (2) @(negedge ref_clk_i);
        check("nvm busy", nc, 1'b1);
        check("idle gated", pce, 8'h5A);
        nvm_busy = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check("nvm done", nc, 1'b0);
        pr = 8'h00;
        smc_cpu_model_i.raise(4'h8);
        repeat (10) @(negedge ref_clk_i);
        check("idle wake", run, 1'b1);
        $display("test nvm and gating done");
    endtask
    task automatic reset_in_sleep;
        smc_cpu_model_i.sleep_cmd(3'h2, 1'b1);
        repeat (2) @(negedge ref_clk_i);
        check("pdown", slp, 1'b1);
        nrst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        awake("after reset");
        check("periph after reset", pce, 8'hFF);
        $display("test reset in sleep done");
    endtask
    initial begin
        #80000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (16) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        awake("reset");
        check("periph reset", pce, 8'hFF);
        sleep_wake(3'h0, 6'h0F, 4'h0, 4'h8, 1'b1);
        sleep_wake(3'h2, 6'h00, 4'hC, 4'h1, 1'b0);
        sleep_wake(3'h3, 6'h05, 4'h8, 4'h4, 1'b0);
        sleep_wake(3'h6, 6'h02, 4'h4, 4'h2, 1'b1);
        sleep_wake(3'h7, 6'h07, 4'h8, 4'h4, 1'b1);
        refused();
        nvm_and_gating();
        reset_in_sleep();
        conclude();
    end
endmodule

// File: testbench/smc_cpu_model.sv
// cpu core and interrupt controller model: issues sleep instructions, holds irq levels
// assumes the controller samples on the rising edge; everything moves on the falling edge
`timescale 1ns/10ps
module smc_cpu_model (
    input  wire logic  ref_clk_i,
    input  wire logic  wake_irq_i,
    output logic [2:0] sleep_mode_select_o,
    output logic       sleep_enable_bit_o,
    output logic       sleep_exec_o,
    output logic [3:0] irq_o
);
    initial begin
        sleep_mode_select_o = 3'h0;
        sleep_enable_bit_o  = 1'h0;
        sleep_exec_o        = 1'h0;
        irq_o               = 4'h0;
    end
    // a serviced interrupt drops all four requests
    always @(negedge ref_clk_i) begin
        if (wake_irq_i === 1'b1) begin
            irq_o = 4'h0;
        end
    end
    // enable written together with the instruction and cleared with it one cycle later
    task automatic sleep_cmd(input logic [2:0] mode, input logic en);
        @(negedge ref_clk_i);
        sleep_mode_select_o = mode;
        sleep_enable_bit_o  = en;
        sleep_exec_o        = 1'h1;
        @(negedge ref_clk_i);
        sleep_exec_o        = 1'h0;
        sleep_enable_bit_o  = 1'h0;
    endtask
    task automatic raise(input logic [3:0] v);
        @(negedge ref_clk_i);
        irq_o = v;
    endtask
endmodule

// File: verilog/smc_ctrl.sv
// sleep mode controller: sleep entry, clock gating per mode, wake and halt
// assumes cpu pulses sleep_exec_i on the sleep instruction; interrupt
// controller sequences service routines by priority after cpu_run_o rises
// Behaviour
// - five sleep modes: idle, power-down, power-save, standby, extended standby.
// - sleep entered only from active; entering stops cpu execution.
// - sleep instruction triggers entry using the configured mode.
// - enabled interrupts or resets wake the device, filtered by mode.
// - on wake the waking interrupt's routine runs, then code after sleep.
// - pending higher priority routines run first, in priority order.
// - cpu held halted four cycles after any wake.
// - stopped system clock source adds its start-up time to wake delay.
// - register file, sram and registers keep contents in sleep.
// - reset during sleep restarts from the reset vector.
// - idle stops cpu and nvm clocks; programming finishes; peripherals run.
// - idle accepts any enabled interrupt as wake source.
// - power-down stops all clocks including rtc clock source; the nvm clock still runs while nvm_busy_i is high.
// - power-down wakes only on twi address match or async port interrupt.
// - power-save is power-down plus running rtc and rtc wake.
// - standby is power-down with system clock sources kept running.
// - extended standby is power-save with system clock sources running.
// - per-peripheral power reduction bits gate individual peripheral clocks.
// - mode code 000 idle, 010/011 down/save, 110/111 standby; others reserved.
// - sleep enable bit must be set for the sleep instruction to act.
`timescale 1ns/10ps
`include "smc_defs.svh"
module smc_ctrl
    import smc_pkg::*;
#(
    parameter int NUM_PERIPH    = 8,
    parameter int OSC_START_CYC = `SMC_OSC_START_CYC
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic                  ce_i,
    input  wire logic [2:0]            sleep_mode_select_i,
    input  wire logic                  sleep_enable_bit_i,
    input  wire logic                  sleep_exec_i,
    input  wire logic                  nvm_busy_i,
    input  wire logic                  rtc_enabled_i,
    input  wire logic                  irq_async_port_i,
    input  wire logic                  irq_twi_addr_i,
    input  wire logic                  irq_rtc_i,
    input  wire logic                  irq_other_i,
    input  wire logic [NUM_PERIPH-1:0] power_reduce_i,
    output logic                       cpu_run_o,
    output logic                       asleep_o,
    output logic                       wake_irq_o,
    output logic                       clk_cpu_en_o,
    output logic                       clk_nvm_en_o,
    output logic                       clk_per_en_o,
    output logic                       clk_rtc_en_o,
    output logic                       sys_osc_en_o,
    output logic                       rtc_osc_en_o,
    output logic [NUM_PERIPH-1:0]      periph_clk_en_o
);
    // elaboration check: the wait counter is 16 bits and at least one gate exists
    if (NUM_PERIPH < 1 || OSC_START_CYC < 1 || OSC_START_CYC > 65535) begin : g_bad_param
        $error("smc_ctrl: parameter out of range");
    end

    typedef struct packed {
        smc_state_type st;
        logic [2:0]    mode;
        logic [15:0]   cnt;
        logic          wake_irq;
        logic          cpu_en;
        logic          nvm_en;
        logic          per_en;
        logic          rtc_en;
        logic          sys_en;
        logic          rtco_en;
        logic [NUM_PERIPH-1:0] pclk;
    } smc_ctrl_type;

    smc_ctrl_type st_q;
    smc_ctrl_type st_d;
    logic         async_s;
    logic         twi_s;
    logic         wake_hit;
    logic         mode_legal;

    // asynchronous wake pins are synchronised; rtc and other irqs are on this clock
    smc_sync3 u_sync_async (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .async_i   (irq_async_port_i),
        .sync_o    (async_s)
    );
    smc_sync3 u_sync_twi (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .async_i   (irq_twi_addr_i),
        .sync_o    (twi_s)
    );

    always_comb begin
        unique case (sleep_mode_select_i)
            `SMC_MODE_IDLE, `SMC_MODE_PDOWN, `SMC_MODE_PSAVE,
            `SMC_MODE_STDBY, `SMC_MODE_ESTDBY: mode_legal = 1'b1;
            default: mode_legal = 1'b0;
        endcase
    end

    // wake filter per held mode
    always_comb begin
        wake_hit = async_s | twi_s;
        unique case (st_q.mode)
            `SMC_MODE_IDLE: wake_hit = wake_hit | irq_rtc_i | irq_other_i;
            `SMC_MODE_PSAVE, `SMC_MODE_ESTDBY:
                wake_hit = wake_hit | (irq_rtc_i & rtc_enabled_i);
            default: wake_hit = wake_hit;
        endcase
    end

    always_comb begin
        st_d = st_q;
        st_d.wake_irq = 1'b0;
        unique case (st_q.st)
            SMC_ACTIVE: begin
                // sleep only with enable set and a legal mode
                if (sleep_exec_i && sleep_enable_bit_i && mode_legal) begin
                    st_d.st     = SMC_ASLEEP;
                    st_d.mode   = sleep_mode_select_i;
                    st_d.cpu_en = 1'b0;
                    st_d.nvm_en = nvm_busy_i;
                    unique case (sleep_mode_select_i)
                        `SMC_MODE_IDLE: begin
                            st_d.per_en = 1'b1;
                            st_d.rtc_en = 1'b1;
                            st_d.sys_en = 1'b1;
                            st_d.rtco_en = 1'b1;
                        end
                        `SMC_MODE_PDOWN: begin
                            st_d.per_en = 1'b0;
                            st_d.rtc_en = 1'b0;
                            st_d.sys_en = 1'b0;
                            st_d.rtco_en = 1'b0;
                        end
                        `SMC_MODE_PSAVE: begin
                            st_d.per_en = 1'b0;
                            st_d.rtc_en = rtc_enabled_i;
                            st_d.sys_en = 1'b0;
                            st_d.rtco_en = rtc_enabled_i;
                        end
                        `SMC_MODE_STDBY: begin
                            st_d.per_en = 1'b0;
                            st_d.rtc_en = 1'b0;
                            st_d.sys_en = 1'b1;
                            st_d.rtco_en = 1'b0;
                        end
                        default: begin
                            st_d.per_en = 1'b0;
                            st_d.rtc_en = rtc_enabled_i;
                            st_d.sys_en = 1'b1;
                            st_d.rtco_en = rtc_enabled_i;
                        end
                    endcase
                end
            end
            SMC_ASLEEP: begin
                // ongoing nvm programming keeps its clock until done
                if (!nvm_busy_i) begin
                    st_d.nvm_en = 1'b0;
                end
                if (wake_hit) begin
                    st_d.per_en  = 1'b1;
                    st_d.rtc_en  = 1'b1;
                    st_d.rtco_en = 1'b1;
                    st_d.nvm_en  = 1'b1;
                    if (!st_q.sys_en) begin
                        st_d.sys_en = 1'b1;
                        st_d.st     = SMC_OSCWT;
                        st_d.cnt    = OSC_START_CYC[15:0] - 16'h0001;
                    end else begin
                        st_d.st  = SMC_HALT;
                        st_d.cnt = {12'h000, `SMC_HALT_CYCLES} - 16'h0001;
                    end
                end
            end
            SMC_OSCWT: begin
                if (st_q.cnt == 16'h0000) begin
                    st_d.st  = SMC_HALT;
                    st_d.cnt = {12'h000, `SMC_HALT_CYCLES} - 16'h0001;
                end else begin
                    st_d.cnt = st_q.cnt - 16'h0001;
                end
            end
            SMC_HALT: begin
                if (st_q.cnt == 16'h0000) begin
                    st_d.st       = SMC_ACTIVE;
                    st_d.cpu_en   = 1'b1;
                    st_d.wake_irq = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt - 16'h0001;
                end
            end
            default: st_d.st = SMC_ACTIVE;
        endcase
        // power reduction gates apply only while the peripheral clock runs
        st_d.pclk = st_d.per_en ? ~power_reduce_i : '0;
    end

    // only clock enables change; no storage is cleared by sleep
    // synchronous reset from any state returns to active
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st_q.st       <= SMC_ACTIVE;
            st_q.mode     <= `SMC_MODE_IDLE;
            st_q.cnt      <= 16'h0000;
            st_q.wake_irq <= 1'b0;
            st_q.cpu_en   <= 1'b1;
            st_q.nvm_en   <= 1'b1;
            st_q.per_en   <= 1'b1;
            st_q.rtc_en   <= 1'b1;
            st_q.sys_en   <= 1'b1;
            st_q.rtco_en  <= 1'b1;
            st_q.pclk     <= '1;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign cpu_run_o       = st_q.cpu_en;
    assign asleep_o        = (st_q.st == SMC_ASLEEP);
    assign wake_irq_o      = st_q.wake_irq;
    assign clk_cpu_en_o    = st_q.cpu_en;
    assign clk_nvm_en_o    = st_q.nvm_en;
    assign clk_per_en_o    = st_q.per_en;
    assign clk_rtc_en_o    = st_q.rtc_en;
    assign sys_osc_en_o    = st_q.sys_en;
    assign rtc_osc_en_o    = st_q.rtco_en;
    assign periph_clk_en_o = st_q.pclk;

    // assertions
    a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && st_q.st == SMC_ACTIVE && sleep_exec_i && sleep_enable_bit_i && mode_legal)
        |=> (st_q.st == SMC_ASLEEP && !cpu_run_o))
        else $error("sleep entry missed");
    a_no_enable: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (st_q.st == SMC_ACTIVE && !sleep_enable_bit_i) |=> cpu_run_o)
        else $error("sleep taken without enable");
    a_halt_four: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ($rose(st_q.st == SMC_HALT) && ce_i) |-> (!cpu_run_o [*4] ##1 1'b1))
        else $error("halt shorter than four cycles");
    a_pdown_clocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (asleep_o && st_q.mode == `SMC_MODE_PDOWN) |-> !(clk_per_en_o | clk_rtc_en_o
        | sys_osc_en_o | rtc_osc_en_o))
        else $error("clock running in power-down");
    a_stdby_osc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (asleep_o && st_q.mode == `SMC_MODE_STDBY) |-> (sys_osc_en_o && !clk_rtc_en_o))
        else $error("standby oscillator state wrong");
    a_idle_per: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (asleep_o && st_q.mode == `SMC_MODE_IDLE) |-> (clk_per_en_o && !clk_cpu_en_o))
        else $error("idle clock state wrong");
    a_pdown_nowake: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && st_q.mode == `SMC_MODE_PDOWN && !async_s && !twi_s)
        |=> asleep_o)
        else $error("illegal wake in power-down");
    a_osc_wait: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && wake_hit && !sys_osc_en_o) |=> (st_q.st == SMC_OSCWT))
        else $error("oscillator start-up skipped");
    a_pr_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ##1 (ce_i && clk_per_en_o && $past(ce_i)) |-> (periph_clk_en_o == ~$past(power_reduce_i)))
        else $error("power reduction gate wrong");
    a_sleep_nocpu: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        asleep_o |-> (!cpu_run_o && !clk_cpu_en_o))
        else $error("cpu running while asleep");
    a_wake_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && wake_irq_o) |-> (cpu_run_o ##1 !wake_irq_o))
        else $error("wake pulse not single");
    a_reserved_ignored: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && st_q.st == SMC_ACTIVE && sleep_exec_i && !mode_legal)
        |=> (!asleep_o && cpu_run_o))
        else $error("reserved mode entered sleep");
    a_psave_clocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (asleep_o && st_q.mode == `SMC_MODE_PSAVE)
        |-> (!clk_per_en_o && !sys_osc_en_o && clk_rtc_en_o == rtc_osc_en_o))
        else $error("power-save clock state wrong");
    a_estdby_osc: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (asleep_o && st_q.mode == `SMC_MODE_ESTDBY)
        |-> (sys_osc_en_o && !clk_per_en_o && clk_rtc_en_o == rtc_osc_en_o))
        else $error("extended standby clock state wrong");
    a_stdby_nowake: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && st_q.mode == `SMC_MODE_STDBY && !async_s && !twi_s)
        |=> asleep_o)
        else $error("illegal wake in standby");
    a_psave_nowake: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && st_q.mode == `SMC_MODE_PSAVE && !async_s && !twi_s
        && !(irq_rtc_i && rtc_enabled_i)) |=> asleep_o)
        else $error("illegal wake in power-save");
    a_idle_wake: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && st_q.mode == `SMC_MODE_IDLE && irq_other_i) |=> !asleep_o)
        else $error("idle ignored an interrupt");
    a_nvm_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && nvm_busy_i && clk_nvm_en_o) |=> clk_nvm_en_o)
        else $error("nvm clock cut during programming");
    a_wake_clocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && asleep_o && wake_hit) |=> (!asleep_o && clk_per_en_o && sys_osc_en_o))
        else $error("wake did not restore clocks");
endmodule

// File: verilog/smc_defs.svh
// sleep mode controller constants: mode codes, field positions, timing counts
// assumes inclusion by bare name from the smc_ctrl module
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_MODE_IDLE     3'h0
`define SMC_MODE_PDOWN    3'h2
`define SMC_MODE_PSAVE    3'h3
`define SMC_MODE_STDBY    3'h6
`define SMC_MODE_ESTDBY   3'h7
`define SMC_WAKE_ASYNC    0
`define SMC_WAKE_TWI      1
`define SMC_WAKE_RTC      2
`define SMC_WAKE_OTHER    3
`define SMC_HALT_CYCLES   4'h4
`define SMC_OSC_START_NS  1000
`define SMC_CLK_PERIOD_NS 4
`define SMC_OSC_START_CYC ((`SMC_OSC_START_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`endif

// File: verilog/smc_pkg.sv
// sleep mode controller types
// assumes smc_defs.svh on the include path
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_ACTIVE = 3'h0,
        SMC_ASLEEP = 3'h1,
        SMC_OSCWT  = 3'h3,
        SMC_HALT   = 3'h2
    } smc_state_type;
endpackage

// File: verilog/smc_sync3.sv
// three-stage synchroniser for one asynchronous level
// assumes the level is steady long enough to be seen twice
`timescale 1ns/10ps
module smc_sync3 (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic async_i,
    output logic      sync_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } smc_sync_type;
    smc_sync_type st_q;
    smc_sync_type st_d;
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.out = st_q.s3;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end
    assign sync_o = st_q.out;
endmodule
